// ==== rtl/pgl_filter.sv ====
// level filter: output follows input after it is stable for len cycles; with fall_only set a rise passes at once
`timescale 1ns/1ps
`default_nettype none
module pgl_filter
    import pgl_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic in_lvl,
    input wire logic [FILT_CW-1:0] len,
    input wire logic fall_only,
    output logic out_q
);
    // filter state
    typedef struct packed {
        logic out;
        logic [FILT_CW-1:0] cnt;
    } pgl_filt_t;

    pgl_filt_t s_q;
    pgl_filt_t s_d;

    // next state: rising edge passes at once when fall_only is set
    always_comb begin
        s_d = s_q;
        if (in_lvl == s_q.out) begin
            s_d.cnt = '0;
        end else if ((fall_only && in_lvl) || len == '0) begin
            s_d.out = in_lvl;
            s_d.cnt = '0;
        end else if (s_q.cnt + 1'b1 >= len) begin
            s_d.out = in_lvl;
            s_d.cnt = '0;
        end else begin
            s_d.cnt = s_q.cnt + 1'b1;
        end
    end

    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign out_q = s_q.out;
endmodule : pgl_filter
`default_nettype wire

// ==== rtl/pgl_pkg.sv ====
// package: offsets, field positions, reset values and timing of the register slice
package pgl_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_GPIO_PIN5_CONTROL = 8'h45;
    localparam logic [7:0] ADDR_SUPPLY_MONITOR_CONFIG = 8'h46;
    localparam logic [7:0] ADDR_LEDA1 = 8'h47;
    localparam logic [7:0] ADDR_LEDA2 = 8'h48;
    // pin register fields
    localparam int GP_SLEEP = 7;
    localparam int GP_SRC = 6;
    localparam int GP_OD = 5;
    localparam int GP_DEB = 4;
    localparam int GP_PD = 3;
    localparam int GP_DIR = 2;
    localparam int GP_LVL = 1;
    localparam int GP_SET = 0;
    // monitor register fields
    localparam int VM_DLY_HI = 6;
    localparam int VM_DLY_LO = 5;
    localparam int VM_SD = 4;
    localparam int VM_RSV3 = 3;
    localparam int VM_GOOD = 2;
    localparam int VM_THR_HI = 1;
    localparam int VM_THR_LO = 0;
    // led a fields
    localparam int LA_RAMP = 5;
    localparam int LA_CUR_HI = 3;
    localparam int LA_T1_HI = 6;
    // writable bit masks; other bits are reserved or live status
    localparam logic [7:0] MASK_GPIO_PIN5_CONTROL = 8'hFD;
    localparam logic [7:0] MASK_SUPPLY_MONITOR_CONFIG = 8'h73;
    localparam logic [7:0] MASK_LEDA1 = 8'h2F;
    localparam logic [7:0] MASK_LEDA2 = 8'h7F;
    // reset values
    localparam logic [7:0] RST_LED_CHANNEL_A = 8'h00;
    localparam logic [7:0] RST_PRELOAD = 8'h00;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;
    // timing, figures in their own units
    localparam int CLK_PERIOD_NS = 10;
    localparam int DEB_SHORT_US = 94;
    localparam int DEB_LONG_US = 156;
    localparam int DLY_50_US = 50;
    localparam int DLY_100_US = 100;
    localparam int DLY_250_US = 250;
    localparam int STEP_MS = 64;
    // derived cycle counts (all exact at 10 ns)
    localparam int DEB_SHORT_CYC = (DEB_SHORT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEB_LONG_CYC = (DEB_LONG_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DLY_50_CYC = (DLY_50_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DLY_100_CYC = (DLY_100_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DLY_250_CYC = (DLY_250_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STEP_CYC = (STEP_MS * 1000000) / CLK_PERIOD_NS;
    // counter widths
    localparam int FILT_CW = 16;
    localparam int TICK_CW = 24;
    // loader states
    typedef enum logic [0:0] {
        PGL_LOAD = 1'b0,
        PGL_RUN = 1'b1
    } pgl_ld_t;
endpackage : pgl_pkg

// ==== rtl/pgl_regs.sv ====
// pin, supply monitor and led a register slice with its pad and monitor logic
`timescale 1ns/1ps
`default_nettype none
module pgl_regs
    import pgl_pkg::*;
#(
    parameter int DEB_SHORT = DEB_SHORT_CYC,
    parameter int DEB_LONG = DEB_LONG_CYC,
    parameter int DLY_50 = DLY_50_CYC,
    parameter int DLY_100 = DLY_100_CYC,
    parameter int DLY_250 = DLY_250_CYC,
    parameter int STEP = STEP_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd_en,
    output logic [7:0] reg_rdata_q,
    input wire logic [7:0] factory_gpio_pin5_control,
    input wire logic [7:0] factory_supply_monitor_config,
    input wire logic sleep_state,
    input wire logic led_channel_c,
    input wire logic pad_in,
    output logic pad_out_q,
    output logic pad_oe_n_q,
    output logic pulldown_enable_q,
    output logic pad_in_sequence_q,
    output logic pad_level_filtered_q,
    input wire logic monitor_cmp,
    output logic [1:0] threshold_select_q,
    output logic supply_good_q,
    output logic monitor_shutdown_q,
    output logic [3:0] led_a_a_q,
    output logic led_a_ramp_on_q,
    output logic [6:0] led_a_phase1_length_q,
    output logic led_a_step_tick_q
);
    // whole block state
    typedef struct packed {
        pgl_ld_t ld;          // factory load pending or running
        logic [7:0] gpio;     // pin register, bit 1 kept zero
        logic [7:0] supply_monitor_config;     // monitor register, status bit kept zero
        logic [7:0] leda1;    // led a current control
        logic [7:0] leda2;    // led a phase one length
        logic pad_s;          // sampled pad level
        logic mon_s;          // sampled comparator level
        logic [7:0] rdata;    // read data
        logic pad_out;        // pad drive value
        logic pad_oe_n;       // pad drive enable, low drives
        logic pad_pd;         // pad pull-down
        logic pad_seq;        // pin takes part in power-up sequence
        logic [1:0] thr;      // comparator threshold code
        logic shutdown;       // switch-off event request
        logic [TICK_CW-1:0] tick_cnt; // 64 ms step divider
        logic tick;           // step pulse
    } pgl_state_t;

    pgl_state_t s_q;
    pgl_state_t s_d;

    logic deb_lvl;            // debounced pad level
    logic good_dly;           // supply good after falling delay
    logic [FILT_CW-1:0] deb_len;
    logic [FILT_CW-1:0] dly_len;
    logic wr_ok;              // write accepted this cycle
    logic drv_lvl;            // level to show on an output pin

    assign wr_ok = reg_wr_en && (s_q.ld == PGL_RUN);

    // debounce length from the select bit
    // debounce interval select
    always_comb begin
        if (s_q.gpio[GP_DEB]) begin
            deb_len = FILT_CW'(DEB_LONG);
        end else begin
            deb_len = FILT_CW'(DEB_SHORT);
        end
    end

    // falling delay length from the delay code
    // falling edge delay
    always_comb begin
        case (s_q.supply_monitor_config[VM_DLY_HI:VM_DLY_LO])
            2'b00: dly_len = '0;
            2'b01: dly_len = FILT_CW'(DLY_50);
            2'b10: dly_len = FILT_CW'(DLY_100);
            2'b11: dly_len = FILT_CW'(DLY_250);
            default: dly_len = '0;
        endcase
    end

    // pad input debounce
    pgl_filter u_deb (
        .clk(clk),
        .rst(rst),
        .in_lvl(s_q.pad_s),
        .len(deb_len),
        .fall_only(1'b0),
        .out_q(deb_lvl)
    );

    // supply good: rise at once, fall after the delay
    pgl_filter u_dly (
        .clk(clk),
        .rst(rst),
        .in_lvl(s_q.mon_s),
        .len(dly_len),
        .fall_only(1'b1),
        .out_q(good_dly)
    );

    // level to drive: source select, then sleep force
    always_comb begin
        if (s_q.gpio[GP_SRC]) begin
            drv_lvl = led_channel_c;
        end else begin
            drv_lvl = s_q.gpio[GP_SET];
        end
        if (sleep_state && s_q.gpio[GP_SLEEP]) begin
            drv_lvl = 1'b0;
        end
    end

    // next state
    always_comb begin
        s_d = s_q;
        s_d.pad_s = pad_in;
        s_d.mon_s = monitor_cmp;
        s_d.tick = 1'b0;
        case (s_q.ld)
            PGL_LOAD: begin
                s_d.gpio = factory_gpio_pin5_control & MASK_GPIO_PIN5_CONTROL;
                s_d.supply_monitor_config = factory_supply_monitor_config & MASK_SUPPLY_MONITOR_CONFIG;
                s_d.ld = PGL_RUN;
            end
            PGL_RUN: begin
                // masked writes keep reserved bits zero
                if (wr_ok) begin
                    case (reg_addr)
                        ADDR_GPIO_PIN5_CONTROL: s_d.gpio = reg_wdata & MASK_GPIO_PIN5_CONTROL;
                        ADDR_SUPPLY_MONITOR_CONFIG: s_d.supply_monitor_config = reg_wdata & MASK_SUPPLY_MONITOR_CONFIG;
                        ADDR_LEDA1: s_d.leda1 = reg_wdata & MASK_LEDA1;
                        ADDR_LEDA2: s_d.leda2 = reg_wdata & MASK_LEDA2;
                        default: s_d.ld = PGL_RUN;
                    endcase
                end
            end
            default: s_d.ld = PGL_LOAD;
        endcase
        // read path, one cycle after the strobe
        if (reg_rd_en) begin
            case (reg_addr)
                // live pad level in bit 1
                ADDR_GPIO_PIN5_CONTROL: s_d.rdata = s_q.gpio | {6'h00, s_q.pad_s, 1'b0};
                ADDR_SUPPLY_MONITOR_CONFIG: s_d.rdata = s_q.supply_monitor_config | (8'h01 << VM_GOOD) & {8{s_q.mon_s}};
                ADDR_LEDA1: s_d.rdata = s_q.leda1;
                ADDR_LEDA2: s_d.rdata = s_q.leda2;
                default: s_d.rdata = RD_UNMAPPED;
            endcase
        end
        // direction: input leaves the pad undriven
        if (!s_q.gpio[GP_DIR]) begin
            s_d.pad_out = 1'b0;
            s_d.pad_oe_n = 1'b1;
        end else if (s_q.gpio[GP_OD]) begin
            s_d.pad_out = 1'b0;
            s_d.pad_oe_n = drv_lvl;
        end else begin
            s_d.pad_out = drv_lvl;
            s_d.pad_oe_n = 1'b0;
        end
        // push-pull output pin joins the power-up sequence
        s_d.pad_seq = s_q.gpio[GP_DIR] && !s_q.gpio[GP_OD];
        s_d.pad_pd = s_q.gpio[GP_PD];
        s_d.thr = s_q.supply_monitor_config[VM_THR_HI:VM_THR_LO];
        s_d.shutdown = s_q.supply_monitor_config[VM_SD] && !good_dly;
        // 64 ms step divider for phase timing
        if (s_q.tick_cnt >= TICK_CW'(STEP - 1)) begin
            s_d.tick_cnt = '0;
            s_d.tick = 1'b1;
        end else begin
            s_d.tick_cnt = s_q.tick_cnt + 1'b1;
        end
    end

    // state register, constants only under reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            s_q.ld <= PGL_LOAD;
            s_q.gpio <= RST_PRELOAD;
            s_q.supply_monitor_config <= RST_PRELOAD;
            s_q.leda1 <= RST_LED_CHANNEL_A;
            s_q.leda2 <= RST_LED_CHANNEL_A;
            s_q.pad_oe_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from flops
    assign reg_rdata_q = s_q.rdata;
    assign pad_out_q = s_q.pad_out;
    assign pad_oe_n_q = s_q.pad_oe_n;
    assign pulldown_enable_q = s_q.pad_pd;
    assign pad_in_sequence_q = s_q.pad_seq;
    assign pad_level_filtered_q = deb_lvl;
    assign threshold_select_q = s_q.thr;
    assign supply_good_q = good_dly;
    assign monitor_shutdown_q = s_q.shutdown;
    assign led_a_a_q = s_q.leda1[LA_CUR_HI:0];
    assign led_a_ramp_on_q = s_q.leda1[LA_RAMP];
    assign led_a_phase1_length_q = s_q.leda2[LA_T1_HI:0];
    assign led_a_step_tick_q = s_q.tick;

    // sleep force on an output pin drives the pad low
    sleep_low_a: assert property (
        @(posedge clk) disable iff (rst)
        (s_q.gpio[GP_DIR] && s_q.gpio[GP_SLEEP] && sleep_state)
            |=> (!pad_out_q && !pad_oe_n_q))
        else $error("sleep force did not pull pin low");

    // led c source reaches a push-pull pin next cycle
    led_source_a: assert property (
        @(posedge clk) disable iff (rst)
        (s_q.gpio[GP_DIR] && !s_q.gpio[GP_OD] && s_q.gpio[GP_SRC]
            && !(sleep_state && s_q.gpio[GP_SLEEP]))
            |=> (pad_out_q == $past(led_channel_c) && !pad_oe_n_q))
        else $error("led c source not driven on pin");

    // open drain never drives a high level
    open_drain_a: assert property (
        @(posedge clk) disable iff (rst)
        (s_q.gpio[GP_DIR] && s_q.gpio[GP_OD])
            |=> (!pad_out_q && (pad_oe_n_q == $past(drv_lvl))))
        else $error("open drain pin drove wrong level");

    // a pull-down write reaches the pad two cycles later
    pulldown_write_a: assert property (
        @(posedge clk) disable iff (rst)
        (wr_ok && reg_addr == ADDR_GPIO_PIN5_CONTROL)
            |=> ##1 (pulldown_enable_q == $past(reg_wdata[GP_PD], 2)))
        else $error("pull-down did not follow write");

    // input direction leaves the pad released
    input_release_a: assert property (
        @(posedge clk) disable iff (rst)
        (s_q.ld == PGL_RUN && !s_q.gpio[GP_DIR]) |=> pad_oe_n_q)
        else $error("input pin was driven");

    // bit 1 returns the sampled pad level
    pad_readback_a: assert property (
        @(posedge clk) disable iff (rst)
        (reg_rd_en && reg_addr == ADDR_GPIO_PIN5_CONTROL)
            |=> (reg_rdata_q[GP_LVL] == $past(s_q.pad_s)))
        else $error("pad level read back wrong");

    // software value reaches a push-pull pin
    soft_value_a: assert property (
        @(posedge clk) disable iff (rst)
        (s_q.gpio[GP_DIR] && !s_q.gpio[GP_OD] && !s_q.gpio[GP_SRC]
            && !(sleep_state && s_q.gpio[GP_SLEEP]))
            |=> (pad_out_q == $past(s_q.gpio[GP_SET])))
        else $error("software value not on pin");

    // no shutdown request while it is masked
    shutdown_mask_a: assert property (
        @(posedge clk) disable iff (rst)
        !s_q.supply_monitor_config[VM_SD] |=> !monitor_shutdown_q)
        else $error("shutdown raised while disabled");

    // reserved monitor bits read as zero
    reserved_zero_a: assert property (
        @(posedge clk) disable iff (rst)
        (reg_rd_en && reg_addr == ADDR_SUPPLY_MONITOR_CONFIG)
            |=> (!reg_rdata_q[7] && !reg_rdata_q[VM_RSV3]))
        else $error("reserved bit read nonzero");

    // a fresh pad change never passes on its first cycle
    debounce_hold_a: assert property (
        @(posedge clk) disable iff (rst)
        (s_q.pad_s != pad_level_filtered_q && deb_len > FILT_CW'(1)
            && $past(s_q.pad_s) == $past(pad_level_filtered_q))
            |=> (pad_level_filtered_q == $past(pad_level_filtered_q)))
        else $error("pad level passed without debounce");

    // a rising monitor level raises supply good at once
    good_rise_a: assert property (
        @(posedge clk) disable iff (rst)
        s_q.mon_s |=> supply_good_q)
        else $error("supply good delayed on rise");

    // status bit reads the sampled comparator level
    status_read_a: assert property (
        @(posedge clk) disable iff (rst)
        (reg_rd_en && reg_addr == ADDR_SUPPLY_MONITOR_CONFIG)
            |=> (reg_rdata_q[VM_GOOD] == $past(s_q.mon_s)))
        else $error("supply status read back wrong");

    // a threshold write reaches the comparator two cycles later
    threshold_write_a: assert property (
        @(posedge clk) disable iff (rst)
        (wr_ok && reg_addr == ADDR_SUPPLY_MONITOR_CONFIG && !reg_wr_en ##0 1'b1)
            or (wr_ok && reg_addr == ADDR_SUPPLY_MONITOR_CONFIG)
            |=> ##1 (threshold_select_q == $past(reg_wdata[VM_THR_HI:VM_THR_LO], 2)))
        else $error("threshold did not follow write");

    // a current write reaches the driver next cycle
    current_write_a: assert property (
        @(posedge clk) disable iff (rst)
        (wr_ok && reg_addr == ADDR_LEDA1)
            |=> (led_a_a_q == $past(reg_wdata[LA_CUR_HI:0])))
        else $error("led a current did not follow write");

    // a phase one write reaches the driver next cycle
    phase_write_a: assert property (
        @(posedge clk) disable iff (rst)
        (wr_ok && reg_addr == ADDR_LEDA2)
            |=> (led_a_phase1_length_q == $past(reg_wdata[LA_T1_HI:0])))
        else $error("phase one length did not follow write");
endmodule : pgl_regs
`default_nettype wire

// ==== verif/pgl_host.sv ====
// host model: drives the register strobe port the way the serial decoder would
`timescale 1ns/1ps
`default_nettype none
module pgl_host (
    input wire logic clk,
    input wire logic [7:0] reg_rdata_q,
    output var logic [7:0] reg_addr,
    output var logic reg_wr_en,
    output var logic [7:0] reg_wdata,
    output var logic reg_rd_en
);
    // idle port: strobes low, address and data scrambled
    initial begin
        reg_addr = 8'h5A;
        reg_wr_en = 1'b0;
        reg_wdata = 8'hA5;
        reg_rd_en = 1'b0;
    end
    // one write, launched and released on falling edges
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        @(negedge clk);
        reg_wr_en = 1'b0;
        // released lines show no stale value
        reg_wdata = ~d;
        reg_addr = ~a;
    endtask : wr
    // one read; data is taken after the strobe edge has landed
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(negedge clk);
        reg_rd_en = 1'b0;
        reg_addr = ~a;
        d = reg_rdata_q;
    endtask : rd
endmodule : pgl_host
`default_nettype wire

// ==== verif/tb.sv ====
// self-checking bench for the pin, monitor and led a register slice
`timescale 1ns/1ps
`default_nettype none
module tb import pgl_pkg::*; ;
    // shortened counts so the run stays brief
    localparam int DS = 4, DL = 6, D50 = 3, D100 = 5, D250 = 8, ST = 16;
    logic clk, rst, reg_wr_en, reg_rd_en, sleep_state, led_channel_c, pad_in, monitor_cmp;
    logic [7:0] reg_addr, reg_wdata, reg_rdata_q, factory_gpio_pin5_control, factory_supply_monitor_config, rv;
    logic pad_out_q, pad_oe_n_q, pulldown_enable_q, pad_in_sequence_q, pad_level_filtered_q;
    logic supply_good_q, monitor_shutdown_q, led_a_ramp_on_q, led_a_step_tick_q;
    logic [1:0] threshold_select_q;
    logic [3:0] led_a_a_q;
    logic [6:0] led_a_phase1_length_q;
    int err_count = 0;
    int n_compared = 0;
    int n, m;
    int dl [4] = '{0, D50, D100, D250};
    // pad table: config byte, and {sleep, led c, out, oe_n, in sequence}
    logic [7:0] pc [9] = '{8'h05, 8'h04, 8'h44, 8'h44, 8'h05, 8'h85, 8'h85, 8'h25, 8'h24};
    logic [4:0] pv [9] = '{5'h05, 5'h01, 5'h0D, 5'h01, 5'h15, 5'h11, 5'h05, 5'h02, 5'h00};
    // device under test and host
    pgl_regs #(.DEB_SHORT(DS), .DEB_LONG(DL), .DLY_50(D50), .DLY_100(D100),
        .DLY_250(D250), .STEP(ST)) pgl_regs_inst (.clk, .rst, .reg_addr, .reg_wr_en,
        .reg_wdata, .reg_rd_en, .reg_rdata_q, .factory_gpio_pin5_control, .factory_supply_monitor_config, .sleep_state,
        .led_channel_c, .pad_in, .pad_out_q, .pad_oe_n_q, .pulldown_enable_q,
        .pad_in_sequence_q, .pad_level_filtered_q, .monitor_cmp, .threshold_select_q,
        .supply_good_q, .monitor_shutdown_q, .led_a_a_q, .led_a_ramp_on_q,
        .led_a_phase1_length_q, .led_a_step_tick_q);
    pgl_host pgl_host_inst (.clk, .reg_rdata_q, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rd_en);
    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // verdict and end of run
    task automatic end_of_test;
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    // compare one observed value with its expectation
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk
    // let derived outputs catch up after a write
    task automatic settle;
        repeat (2) @(negedge clk);
    endtask : settle
    task automatic w(input logic [7:0] a, input logic [7:0] d);
        pgl_host_inst.wr(a, d);
        settle();
    endtask : w
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        pgl_host_inst.rd(a, rv);
        chk(rv, exp, "read data");
    endtask : rchk
    // count falling edges until a watched output reaches a level, bounded
    task automatic meas(input int sel, input logic lvl, output int cnt);
        logic s;
        cnt = 0;
        do begin
            @(negedge clk);
            cnt++;
            case (sel)
                0: s = pad_level_filtered_q;
                1: s = supply_good_q;
                default: s = led_a_step_tick_q;
            endcase
        end while (s !== lvl && cnt < 300);
        if (s !== lvl) begin
            err_count++;
            $display("unexpected at %0t: wait ran out", $time);
            end_of_test();
        end
    endtask : meas
    // reset held five cycles, then the loader edge passes
    task automatic do_reset;
        rst = 1'b1;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        settle();
    endtask : do_reset
    // main sequence
    initial begin
        rst = 1'b1;
        sleep_state = 1'b0;
        led_channel_c = 1'b0;
        pad_in = 1'b0;
        monitor_cmp = 1'b1;
        factory_gpio_pin5_control = 8'h0A;
        factory_supply_monitor_config = 8'h99;
        do_reset();
        rchk(ADDR_GPIO_PIN5_CONTROL, 8'h08);
        chk(pulldown_enable_q, 8'h01, "pull-down");
        rchk(ADDR_SUPPLY_MONITOR_CONFIG, 8'h15);
        chk(threshold_select_q, 8'h01, "threshold");
        rchk(ADDR_LEDA1, 8'h00);
        rchk(ADDR_LEDA2, 8'h00);
        $display("test reset_values done");
        w(ADDR_LEDA1, 8'hFF);
        rchk(ADDR_LEDA1, 8'h2F);
        chk(led_a_a_q, 8'h0F, "current");
        chk(led_a_ramp_on_q, 8'h01, "ramp");
        w(ADDR_LEDA2, 8'hFF);
        rchk(ADDR_LEDA2, 8'h7F);
        chk(led_a_phase1_length_q, 8'h7F, "phase one");
        w(ADDR_SUPPLY_MONITOR_CONFIG, 8'hFF);
        rchk(ADDR_SUPPLY_MONITOR_CONFIG, 8'h77);
        chk(threshold_select_q, 8'h03, "threshold");
        w(8'h50, 8'hFF);
        rchk(8'h50, 8'h00);
        w(ADDR_LEDA1, 8'h10);
        rchk(ADDR_LEDA1, 8'h00);
        chk(led_a_ramp_on_q, 8'h00, "ramp");
        meas(2, 1'b1, n);
        meas(2, 1'b0, n);
        meas(2, 1'b1, m);
        chk(n + m == ST, 8'h01, "step period");
        $display("test registers done");
        for (int i = 0; i < 9; i++) begin
            sleep_state = pv[i][4];
            led_channel_c = pv[i][3];
            w(ADDR_GPIO_PIN5_CONTROL, pc[i]);
            chk({pad_out_q, pad_oe_n_q, pad_in_sequence_q}, pv[i][2:0], "pad");
        end
        sleep_state = 1'b0;
        w(ADDR_GPIO_PIN5_CONTROL, 8'h00);
        chk({pad_oe_n_q, pad_in_sequence_q}, 8'h02, "input pad");
        chk(pulldown_enable_q, 8'h00, "pull-down");
        $display("test pad_drive done");
        pad_in = 1'b1;
        meas(0, 1'b1, n);
        chk(n >= DS + 1 && n <= DS + 2, 8'h01, "short debounce");
        rchk(ADDR_GPIO_PIN5_CONTROL, 8'h02);
        w(ADDR_GPIO_PIN5_CONTROL, 8'h10);
        pad_in = 1'b0;
        meas(0, 1'b0, n);
        chk(n >= DL + 1 && n <= DL + 2, 8'h01, "long debounce");
        rchk(ADDR_GPIO_PIN5_CONTROL, 8'h10);
        w(ADDR_GPIO_PIN5_CONTROL, 8'h04);
        pad_in = 1'b1;
        rchk(ADDR_GPIO_PIN5_CONTROL, 8'h06);
        $display("test pad_input done");
        for (int c = 0; c < 4; c++) begin
            w(ADDR_SUPPLY_MONITOR_CONFIG, {1'b0, c[1:0], 5'h13});
            chk(monitor_shutdown_q, 8'h00, "switch-off");
            monitor_cmp = 1'b0;
            meas(1, 1'b0, n);
            chk(n >= dl[c] + 1 && n <= dl[c] + 3, 8'h01, "fall delay");
            settle();
            chk(monitor_shutdown_q, 8'h01, "switch-off");
            rchk(ADDR_SUPPLY_MONITOR_CONFIG, {1'b0, c[1:0], 5'h13});
            monitor_cmp = 1'b1;
            meas(1, 1'b1, n);
            chk(n, 8'h02, "rise delay");
        end
        w(ADDR_SUPPLY_MONITOR_CONFIG, 8'h03);
        monitor_cmp = 1'b0;
        meas(1, 1'b0, n);
        settle();
        chk(monitor_shutdown_q, 8'h00, "switch-off masked");
        monitor_cmp = 1'b1;
        $display("test monitor done");
        w(ADDR_LEDA1, 8'h2A);
        factory_supply_monitor_config = 8'h62;
        do_reset();
        rchk(ADDR_LEDA1, 8'h00);
        rchk(ADDR_LEDA2, 8'h00);
        rchk(ADDR_SUPPLY_MONITOR_CONFIG, 8'h66);
        $display("test second_reset done");
        end_of_test();
    end
endmodule : tb
`default_nettype wire
